/* File: cdio_far_model.sv */
// far side of the port: pull-ups, external switches and the forming engine
`timescale 1ns/100ps
module cdio_far_model #(
   parameter int SAVE_LAT = 3
) (
   // clock
   input wire logic pclk,
   // pins
   input wire logic [15:0] dio_oe_n,
   input wire logic [15:0] ext_low,
   output logic [15:0] dio_in,
   // forming engine
   input wire logic save_req,
   output logic save_done
);
   int cnt;
   // pull-ups hold a released line high; a closed switch or the port pulls it low
   assign dio_in = dio_oe_n & ~ext_low;
   // saving the state takes a few cycles, never answered at once
   assign save_done = save_req && (cnt >= SAVE_LAT);
   always_ff @(posedge pclk) begin
      cnt <= save_req ? cnt + 1 : 0;
   end
endmodule // cdio_far_model

/* File: cdio_pkg.sv */
// package for the configurable digital i/o port
package cdio_pkg;
   localparam int NUM_LINES = 16;
   // register byte offsets
   localparam logic [11:0] OFF_DIR = 12'h000;
   localparam logic [11:0] OFF_POL = 12'h004;
   localparam logic [11:0] OFF_ISO = 12'h008;
   localparam logic [11:0] OFF_OUT = 12'h00C;
   localparam logic [11:0] OFF_IN = 12'h010;
   localparam logic [11:0] OFF_SFSEL = 12'h014;
   localparam logic [11:0] OFF_CTRL = 12'h018;
   localparam logic [11:0] OFF_STAT = 12'h01C;
   localparam logic [11:0] OFF_IRQ_ST = 12'h020;
   localparam logic [11:0] OFF_IRQ_MSK = 12'h024;
   localparam logic [11:0] OFF_PDIR = 12'h028;
   // line modes, two bits per line in the direction register
   localparam logic [1:0] MODE_IN = 2'h0;
   localparam logic [1:0] MODE_OUT = 2'h1;
   localparam logic [1:0] MODE_BIDIR = 2'h2;
   // special function select: 4 bits line index + enable per function
   localparam int SF_EFI = 0;
   localparam int SF_EFO = 1;
   localparam int SF_STOP = 2;
   localparam int SF_TRIG = 3;
   localparam int SF_PFI = 4;
   localparam int SF_PFO = 5;
   localparam int SF_NUM = 6;
   // ctrl bits
   localparam int CTRL_FAULT_CLR = 0;
   localparam int CTRL_PF_EN = 1;
   localparam int CTRL_SAVE_DONE = 2;
   // status / irq bits
   localparam int ST_FAULT = 0;
   localparam int ST_STOP = 1;
   localparam int ST_TRIG = 2;
   localparam int ST_PF = 3;
   localparam int IRQ_BITS = 4;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [15:0] RST_OUT = 16'hFFFF;
   // sequencer states
   typedef enum logic [4:0] {
      SEQ_IDLE = 5'b00001,
      SEQ_RUN = 5'b00010,
      SEQ_HALT = 5'b00100,
      SEQ_FAULT = 5'b01000,
      SEQ_SAVE = 5'b10000
   } cdio_seq_t;
endpackage

/* File: cdio_port.sv */
// configurable 16-line digital i/o port with special functions, apb registers
`timescale 1ns/100ps
module cdio_port #(
   parameter int NL = cdio_pkg::NUM_LINES
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins, open collector: oe low means the line is pulled low
   input wire logic [NL-1:0] dio_in,
   output logic [NL-1:0] dio_out,
   output logic [NL-1:0] dio_oe_n,
   // sequencer handshake with the forming engine
   output logic seq_running,
   output logic save_req,
   input wire logic save_done,
   // interrupt
   output logic irq
);
   import cdio_pkg::*;

   logic [2*NL-1:0] dir_r;
   logic [NL-1:0] pol_r;
   logic [NL/2-1:0] iso_r;
   logic [NL-1:0] out_r;
   logic [5*SF_NUM-1:0] sfsel_r;
   logic pf_en_r;
   logic [NL-1:0] sync1_r, sync2_r;
   logic [IRQ_BITS-1:0] irq_st_r, irq_msk_r;
   logic fault_out_r, pf_out_r;
   logic trig_d_r, pfi_d_r;
   cdio_seq_t seq_r;
   cdio_seq_t seq_nxt;
   logic [NL-1:0] log_in;
   logic efi, stop_in, trig_in, pfi;
   logic wr_en, addr_ok, fault_clr;
   logic [IRQ_BITS-1:0] ev;

   // effective polarity: odd line of an isolated pair uses the even bit
   function automatic logic eff_pol(input logic [NL-1:0] p, input logic [NL/2-1:0] iso, input int i);
      eff_pol = (iso[i/2]) ? p[i & ~1] : p[i];
   endfunction

   // pick a synchronised logical input for a special function
   function automatic logic sf_pick(input logic [5*SF_NUM-1:0] sel, input logic [NL-1:0] v, input int f);
      logic [3:0] idx;
      idx = sel[5*f +: 4];
      sf_pick = sel[5*f+4] & v[idx];
   endfunction

   // level a line shows before polarity; a special output overrides general purpose
   function automatic logic line_lvl(input int i);
      line_lvl = out_r[i];
      if (sfsel_r[5*SF_EFO+4] && sfsel_r[5*SF_EFO +: 4] == 4'(i)) line_lvl = fault_out_r;
      if (sfsel_r[5*SF_PFO+4] && sfsel_r[5*SF_PFO +: 4] == 4'(i)) line_lvl = pf_out_r;
   endfunction

   // two stage synchroniser, stage one read only by stage two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= dio_in;
         sync2_r <= sync1_r;
      end
   end

   // logical input level after polarity
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         log_in[i] = sync2_r[i] ^ pol_r[i];
      end
   end

   assign efi = sf_pick(sfsel_r, log_in, SF_EFI);
   assign stop_in = sf_pick(sfsel_r, log_in, SF_STOP);
   assign trig_in = sf_pick(sfsel_r, log_in, SF_TRIG);
   assign pfi = sf_pick(sfsel_r, log_in, SF_PFI) & pf_en_r;

   // apb decode, zero wait states
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign addr_ok = (paddr <= OFF_PDIR) && (paddr[1:0] == 2'b00);
   assign pslverr = psel & penable & ~addr_ok;
   assign fault_clr = wr_en && paddr == OFF_CTRL && pwdata[CTRL_FAULT_CLR];

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= '0;
         pol_r <= '0;
         iso_r <= '0;
         out_r <= RST_OUT;
         sfsel_r <= '0;
         pf_en_r <= 1'b0;
         irq_msk_r <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            OFF_DIR: dir_r <= pwdata[2*NL-1:0];
            OFF_POL: pol_r <= pwdata[NL-1:0];
            OFF_ISO: iso_r <= pwdata[NL/2-1:0];
            OFF_OUT: out_r <= pwdata[NL-1:0];
            OFF_SFSEL: sfsel_r <= pwdata[5*SF_NUM-1:0];
            OFF_CTRL: pf_en_r <= pwdata[CTRL_PF_EN];
            OFF_IRQ_MSK: irq_msk_r <= pwdata[IRQ_BITS-1:0];
            default: ;
         endcase
      end
   end

   // pin drive: a special output function overrides the general purpose level
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         logic lvl;
         logic [1:0] md;
         lvl = line_lvl(i);
         md = dir_r[2*i +: 2];
         if (iso_r[i/2]) begin
            // one isolator per pair: both pins follow the even line's level and polarity
            dio_out[i] = 1'b0;
            dio_oe_n[i] = line_lvl(i & ~1) ^ eff_pol(pol_r, iso_r, i);
         end else begin
            dio_out[i] = 1'b0;
            // input mode never pulls; output and bidir pull low when level xor polarity is low
            dio_oe_n[i] = (md == MODE_IN) ? 1'b1 : (lvl ^ pol_r[i]);
         end
      end
   end

   // sequencer
   always_comb begin
      seq_nxt = seq_r;
      unique case (seq_r)
         SEQ_IDLE: if (pfi) seq_nxt = SEQ_SAVE; else if (efi) seq_nxt = SEQ_FAULT;
            else if (trig_in & ~trig_d_r) seq_nxt = SEQ_RUN;
         SEQ_RUN: if (pfi) seq_nxt = SEQ_SAVE; else if (efi) seq_nxt = SEQ_FAULT;
            else if (stop_in) seq_nxt = SEQ_HALT;
         SEQ_HALT: if (pfi) seq_nxt = SEQ_SAVE; else if (efi) seq_nxt = SEQ_FAULT;
            else if (!stop_in) seq_nxt = SEQ_RUN;
         SEQ_FAULT: if (pfi) seq_nxt = SEQ_SAVE; else if (fault_clr && !efi) seq_nxt = SEQ_IDLE;
         SEQ_SAVE: if (!pfi && pf_out_r) seq_nxt = SEQ_IDLE;
         default: seq_nxt = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r <= SEQ_IDLE;
         trig_d_r <= 1'b0;
         pfi_d_r <= 1'b0;
      end else begin
         seq_r <= seq_nxt;
         trig_d_r <= trig_in;
         pfi_d_r <= pfi;
      end
   end

   assign seq_running = (seq_r == SEQ_RUN);
   assign save_req = (seq_r == SEQ_SAVE) & ~pf_out_r;

   // fault output: set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fault_out_r <= 1'b0;
      else if (efi) fault_out_r <= 1'b1;
      else if (fault_clr) fault_out_r <= 1'b0;
   end

   // power fail output once the engine reports the state saved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pf_out_r <= 1'b0;
      else if (seq_r == SEQ_SAVE && save_done) pf_out_r <= 1'b1;
      else if (seq_r != SEQ_SAVE) pf_out_r <= 1'b0;
   end

   // interrupt status, write one to clear, new event wins
   assign ev[ST_FAULT] = efi & ~fault_out_r;
   assign ev[ST_STOP] = (seq_r == SEQ_RUN) & stop_in;
   assign ev[ST_TRIG] = trig_in & ~trig_d_r;
   assign ev[ST_PF] = pfi & ~pfi_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_st_r <= '0;
      else if (wr_en && paddr == OFF_IRQ_ST) irq_st_r <= (irq_st_r & ~pwdata[IRQ_BITS-1:0]) | ev;
      else irq_st_r <= irq_st_r | ev;
   end

   assign irq = |(irq_st_r & irq_msk_r);

   // read data from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= RST_ZERO;
      else if (psel & ~penable & ~pwrite) begin
         unique case (paddr)
            OFF_DIR: prdata <= dir_r;
            OFF_POL: prdata <= {16'h0000, pol_r};
            OFF_ISO: prdata <= {24'h00_0000, iso_r};
            OFF_OUT: prdata <= {16'h0000, out_r};
            OFF_IN: prdata <= {16'h0000, log_in};
            OFF_SFSEL: prdata <= {2'b00, sfsel_r};
            OFF_CTRL: prdata <= {30'h0000_0000, pf_en_r, 1'b0};
            OFF_STAT: prdata <= {23'h00_0000, seq_r, save_req, pf_out_r, fault_out_r, seq_running};
            OFF_IRQ_ST: prdata <= {28'h000_0000, irq_st_r};
            OFF_IRQ_MSK: prdata <= {28'h000_0000, irq_msk_r};
            OFF_PDIR: prdata <= {16'h0000, sync2_r};
            default: prdata <= RST_ZERO;
         endcase
      end
   end

   // checks: fault path
   a_fault_sets: assert property (@(posedge pclk) disable iff (!presetn)
      efi |=> fault_out_r)
      else $error("fault output not raised");

   a_fault_state: assert property (@(posedge pclk) disable iff (!presetn)
      efi && !pfi && seq_r != SEQ_SAVE |=> seq_r == SEQ_FAULT)
      else $error("fault input did not stop the sequence");

   a_fault_holds: assert property (@(posedge pclk) disable iff (!presetn)
      fault_out_r && !fault_clr |=> fault_out_r)
      else $error("fault output dropped without clear");

   a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
      fault_clr && !efi |=> !fault_out_r)
      else $error("fault clear ignored");

   a_fault_stays: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_FAULT && !fault_clr && !pfi |=> seq_r == SEQ_FAULT)
      else $error("fault state left without clear");

   // checks: stop and trigger
   a_stop_nofault: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_RUN && stop_in && !efi && !pfi && !fault_out_r |=> seq_r == SEQ_HALT && !fault_out_r)
      else $error("stop misbehaved");

   a_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_HALT && stop_in && !efi && !pfi |=> seq_r == SEQ_HALT)
      else $error("halt left while stop held");

   a_stop_resume: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_HALT && !stop_in && !efi && !pfi |=> seq_running)
      else $error("no resume");

   a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_IDLE && trig_in && !trig_d_r && !efi && !pfi |=> seq_running)
      else $error("no start");

   a_idle_waits: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_IDLE && !(trig_in && !trig_d_r) && !efi && !pfi |=> seq_r == SEQ_IDLE)
      else $error("sequence left idle without trigger");

   // checks: power fail
   a_pf_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !pf_en_r |-> !pfi)
      else $error("power fail input acted while disabled");

   a_pf_save: assert property (@(posedge pclk) disable iff (!presetn)
      pfi |=> seq_r == SEQ_SAVE)
      else $error("power fail not saving");

   a_save_req: assert property (@(posedge pclk) disable iff (!presetn)
      save_req |-> seq_r == SEQ_SAVE && !pf_out_r)
      else $error("save request outside saving");

   a_save_leave: assert property (@(posedge pclk) disable iff (!presetn)
      seq_r == SEQ_SAVE && !pfi && pf_out_r |=> seq_r == SEQ_IDLE)
      else $error("saving not left after power returned");

   a_pf_out: assert property (@(posedge pclk) disable iff (!presetn)
      save_req && save_done |=> pf_out_r)
      else $error("power fail output late");

   a_pf_out_hold: assert property (@(posedge pclk) disable iff (!presetn)
      pf_out_r && seq_r == SEQ_SAVE |=> pf_out_r)
      else $error("power fail output dropped while saving");

   // checks: inputs, registers and interrupts
   a_sync_two: assert property (@(posedge pclk) disable iff (!presetn)
      sync2_r == $past(dio_in, 2) || !$past(presetn, 1) || !$past(presetn, 2))
      else $error("sync depth wrong");

   a_in_read: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == OFF_IN |=> prdata == {16'h0000, $past(log_in)})
      else $error("input read not the line level");

   a_pol_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFF_POL |=> pol_r == NL'($past(pwdata)))
      else $error("polarity write lost");

   a_out_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFF_OUT |=> out_r == NL'($past(pwdata)))
      else $error("output write lost");

   a_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && paddr > OFF_PDIR |-> pslverr)
      else $error("unmapped address not refused");

   a_irq_sets: assert property (@(posedge pclk) disable iff (!presetn)
      ev != '0 |=> (irq_st_r & $past(ev)) == $past(ev))
      else $error("event lost in status");

   a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_en && paddr == OFF_IRQ_ST) |=> ($past(irq_st_r) & ~irq_st_r) == '0)
      else $error("status bit dropped without clear");

   a_trig_event: assert property (@(posedge pclk) disable iff (!presetn)
      trig_in && !trig_d_r |=> irq_st_r[ST_TRIG])
      else $error("trigger edge not flagged");

   // per-line pin checks
   for (genvar g = 0; g < NL; g++) begin : g_line_chk
      a_in_release: assert property (@(posedge pclk) disable iff (!presetn)
         !iso_r[g/2] && dir_r[2*g +: 2] == MODE_IN |-> dio_oe_n[g])
         else $error("input line pulled low");

      a_pair_equal: assert property (@(posedge pclk) disable iff (!presetn)
         iso_r[g/2] |-> dio_oe_n[g] == dio_oe_n[g ^ 1])
         else $error("isolated pair pins differ");
   end
   c_fault: cover property (@(posedge pclk) disable iff (!presetn) seq_r == SEQ_FAULT ##[1:20] seq_r == SEQ_IDLE);
   c_halt: cover property (@(posedge pclk) disable iff (!presetn) seq_r == SEQ_HALT ##1 seq_running);
   c_pf: cover property (@(posedge pclk) disable iff (!presetn) save_req ##1 pf_out_r);
endmodule // cdio_port

/* File: cdio_port_tb.sv */
// self-checking bench for the configurable digital i/o port
`timescale 1ns/100ps
module cdio_port_tb;
   import cdio_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, seq_running, save_req, save_done, irq;
   logic [15:0] dio_in, dio_out, dio_oe_n, v, e, ext_low = 16'h0000;
   logic [32:0] rq[$];
   logic [32:0] pq[$];
   int n_errors = 0, n_checks = 0, seed = 80;
   event pin_ev;
   cdio_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dio_in(dio_in), .dio_out(dio_out), .dio_oe_n(dio_oe_n), .seq_running(seq_running),
      .save_req(save_req), .save_done(save_done), .irq(irq));
   cdio_far_model far (.pclk(pclk), .dio_oe_n(dio_oe_n), .ext_low(ext_low), .dio_in(dio_in),
      .save_req(save_req), .save_done(save_done));
   initial forever #2.5 pclk = ~pclk;
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdx(input logic [11:0] a, input logic [31:0] d, input logic err);
      rq.push_back({err, d});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // flags {irq, running, save_req} and pin enables, looked at mid-cycle
   task automatic pin(input logic [18:0] x);
      pq.push_back({14'h0000, x});
      @(negedge pclk);
      -> pin_ev;
   endtask
   // switch closure or release on a line, then time for two sync flops and the sequencer
   task automatic sw(input int k, input logic c);
      @(posedge pclk);
      ext_low[k] <= c;
      repeat (6) @(posedge pclk);
   endtask
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, rq.pop_front());
   always @(pin_ev) cmp({14'h0000, irq, seq_running, save_req, dio_oe_n}, pq.pop_front());
   initial begin
      #60000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      pin({3'b000, 16'hFFFF});
      rdx(OFF_DIR, 32'h0000_0000, 1'b0);
      rdx(OFF_OUT, 32'h0000_FFFF, 1'b0);
      rdx(12'h02C, 32'h0000_0000, 1'b1);
      rdx(12'h002, 32'h0000_0000, 1'b1);
      // switch inputs are active low so the pull-up idle level reads inactive
      wr(OFF_POL, 32'h0000_01DA);
      wr(OFF_DIR, 32'h0024_0455);
      wr(OFF_ISO, 32'h0000_0002);
      wr(OFF_SFSEL, 32'h338B_DAB4);
      rdx(OFF_SFSEL, 32'h338B_DAB4, 1'b0);
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         v[3] = v[2];
         ext_low <= {5'h00, v[11], 10'h000};
         wr(OFF_OUT, {16'h0000, v});
         e = 16'hF9D0 | (v & 16'h040D) | (~v & 16'h0002);
         pin({3'b000, e});
         repeat (3) @(posedge pclk);
         rdx(OFF_IN, {16'h0000, (e & ~ext_low) ^ 16'h01DA}, 1'b0);
      end
      ext_low <= 16'h0000;
      wr(OFF_POL, 32'h0000_01DE);
      wr(OFF_OUT, 32'h0000_0004);
      pin({3'b000, 16'hF9D2});
      wr(OFF_POL, 32'h0000_01DA);
      wr(OFF_OUT, 32'h0000_0000);
      wr(OFF_IRQ_MSK, 32'h0000_0001);
      sw(7, 1'b1);
      pin({3'b010, 16'hF9D2});
      sw(7, 1'b0);
      sw(6, 1'b1);
      pin({3'b000, 16'hF9D2});
      sw(6, 1'b0);
      pin({3'b010, 16'hF9D2});
      sw(4, 1'b1);
      pin({3'b100, 16'hF9F2});
      sw(4, 1'b0);
      pin({3'b100, 16'hF9F2});
      rdx(OFF_IRQ_ST, 32'h0000_0007, 1'b0);
      wr(OFF_CTRL, 32'h0000_0001);
      wr(OFF_IRQ_ST, 32'h0000_0007);
      pin({3'b000, 16'hF9D2});
      rdx(OFF_IRQ_ST, 32'h0000_0000, 1'b0);
      wr(OFF_IRQ_MSK, 32'h0000_0008);
      wr(OFF_CTRL, 32'h0000_0002);
      sw(7, 1'b1);
      sw(7, 1'b0);
      pin({3'b010, 16'hF9D2});
      sw(8, 1'b1);
      repeat (3) @(posedge pclk);
      pin({3'b100, 16'hFBD2});
      rdx(OFF_STAT, 32'h0000_0104, 1'b0);
      sw(8, 1'b0);
      repeat (2) @(posedge pclk);
      conclude();
   end
endmodule // cdio_port_tb
